//--- design/acs_pkg.sv
// constants and types for the conversion sequencer
// What this block does
// - a conversion is 4 sample clocks then 8 convert clocks, 12 total
// - once launched the sequence runs alone, no processor help needed
// - start high holds converter in reset; its falling edge launches
// - busy high during conversion, low at end; result byte then valid
// - power enable low switches the converter circuitry off
// - result is unsigned 8-bit, full scale ff, step is ref over 256
// - code transitions sit half a step low, last one and a half low
// - completion sets irq flag, which raises the interrupt only while global and converter irq enables are both set
// - channel codes 0 to 4 pick inputs, 5 to 15 a floating channel
// - divider codes 0 to 7 divide system clock by 1 up to 128
// - reference code 01 picks the supply, anything else the pin
package acs_pkg;
	localparam int ACS_SAMPLE_CLKS = 4;
	localparam int ACS_CONVERT_CLKS = 8;
	localparam int ACS_TOTAL_CLKS = ACS_SAMPLE_CLKS + ACS_CONVERT_CLKS;
	localparam int ACS_DATA_W = 8;
	localparam int ACS_CHAN_W = 4;
	localparam int ACS_NUM_INPUTS = 5;
	localparam int ACS_DIV_W = 3;
	localparam int ACS_PRESC_W = 7;
	localparam logic [1:0] ACS_REF_SUPPLY = 2'h1;
	localparam logic [7:0] ACS_RESULT_RST = 8'h00;
	localparam logic [6:0] ACS_PRESC_RST = 7'h00;
	localparam logic [3:0] ACS_CNT_RST = 4'h0;

	typedef enum logic [1:0] {ACS_IDLE, ACS_HOLD, ACS_SAMPLE, ACS_CONVERT} acs_state_e;

	typedef struct packed {
		logic power_enable;
		logic start;
		logic [ACS_DIV_W-1:0] clock_div_sel;
		logic [ACS_CHAN_W-1:0] input_channel_sel;
		logic [1:0] ref_source_sel;
	} acs_ctrl_s;

	typedef struct packed {
		logic busy;
		logic irq_flag;
		logic irq;
		logic [ACS_DATA_W-1:0] result;
	} acs_stat_s;
endpackage : acs_pkg

//--- design/acs_sar_core.sv
// successive-approximation bit search driven by converter clock ticks
`timescale 1ns/1ps
module acs_sar_core
	import acs_pkg::*;
#(
	parameter int DATA_W = ACS_DATA_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic step,
	input wire logic cmp_above,
	output logic [DATA_W-1:0] trial,
	output logic [DATA_W-1:0] code
);
	logic [DATA_W-1:0] mask_ff;
	logic [DATA_W-1:0] code_ff;
	logic [DATA_W-1:0] nxt_mask;
	logic [DATA_W-1:0] nxt_code;

	// comparator sees trial; above means keep the bit being tried
	assign trial = code_ff | mask_ff;
	assign nxt_code = clear ? '0 : (step ? (cmp_above ? trial : code_ff) : code_ff);
	assign nxt_mask = clear ? {1'b1, {(DATA_W-1){1'b0}}} : (step ? (mask_ff >> 1) : mask_ff);
	assign code = code_ff;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_ff <= '0;
			code_ff <= '0;
		end else begin
			mask_ff <= nxt_mask;
			code_ff <= nxt_code;
		end
	end
endmodule : acs_sar_core

//--- design/acs_sequencer.sv
// conversion sequencer: divider, start handling, timing, result and irq
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int DATA_W = ACS_DATA_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire acs_ctrl_s ctrl,
	input wire logic global_irq_enable,
	input wire logic conv_irq_enable,
	input wire logic irq_flag_clear,
	input wire logic cmp_above_pin,
	output logic [DATA_W-1:0] dac_trial,
	output logic [ACS_NUM_INPUTS-1:0] input_select,
	output logic ref_from_supply,
	output logic analog_power,
	output logic sample_switch,
	output acs_stat_s stat
);
	acs_state_e state_ff, nxt_state;
	logic [ACS_PRESC_W-1:0] presc_ff;
	logic [3:0] cnt_ff, nxt_cnt;
	logic cmp_meta_ff, cmp_sync_ff;
	logic start_d_ff;
	logic busy_ff, irq_flag_ff, irq_ff;
	logic [DATA_W-1:0] result_ff, trial_ff;
	logic [ACS_NUM_INPUTS-1:0] sel_ff;
	logic ref_ff, power_ff, sample_ff;
	logic [DATA_W-1:0] sar_trial, sar_code;

	// divider code n ticks every 2**n system clocks
	function automatic logic [ACS_PRESC_W-1:0] div_mask(input logic [ACS_DIV_W-1:0] sel);
		div_mask = ACS_PRESC_W'((8'h01 << sel) - 8'h01);
	endfunction : div_mask

	// a tick closes a converter period, so the first period after launch is as
	// long as every later one and twelve ticks span twelve whole periods
	wire [ACS_PRESC_W-1:0] tick_mask = div_mask(ctrl.clock_div_sel);
	wire tick = (presc_ff & tick_mask) == tick_mask;
	wire start_fall = start_d_ff && !ctrl.start;
	wire active = (state_ff == ACS_SAMPLE) || (state_ff == ACS_CONVERT);
	wire last_tick = tick && (state_ff == ACS_CONVERT) && (cnt_ff == 4'(ACS_TOTAL_CLKS - 1));
	wire done = last_tick && ctrl.power_enable;
	wire sar_step = tick && (state_ff == ACS_CONVERT);
	wire sar_clear = (state_ff == ACS_SAMPLE);
	wire irq_now = irq_flag_ff && global_irq_enable && conv_irq_enable;

	// hardware runs each phase on its own from the tick count
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ACS_IDLE: if (ctrl.start) nxt_state = ACS_HOLD;
			ACS_HOLD: begin
				nxt_cnt = ACS_CNT_RST;
				if (start_fall) nxt_state = ACS_SAMPLE;
			end
			ACS_SAMPLE: if (tick) begin
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff == 4'(ACS_SAMPLE_CLKS - 1)) nxt_state = ACS_CONVERT;
			end
			ACS_CONVERT: if (tick) begin
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff == 4'(ACS_TOTAL_CLKS - 1)) nxt_state = ACS_IDLE;
			end
			default: nxt_state = ACS_IDLE;
		endcase
		// a raised start restarts the sequence, power loss aborts it
		if (ctrl.start && state_ff != ACS_IDLE) nxt_state = ACS_HOLD;
		if (!ctrl.power_enable) nxt_state = ACS_IDLE;
	end

	acs_sar_core #(.DATA_W(DATA_W)) u_sar (
		.clk(clk),
		.reset_n(reset_n),
		.clear(sar_clear),
		.step(sar_step),
		.cmp_above(cmp_sync_ff),
		.trial(sar_trial),
		.code(sar_code)
	);

	// the final step's bit is folded in here so the result is complete
	wire [DATA_W-1:0] final_code = cmp_sync_ff ? sar_trial : sar_code;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ACS_IDLE;
			cnt_ff <= ACS_CNT_RST;
			presc_ff <= ACS_PRESC_RST;
			start_d_ff <= 1'b0;
			cmp_meta_ff <= 1'b0;
			cmp_sync_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			// prescaler held in reset with the start bit so phases align
			presc_ff <= (ctrl.start || !active) ? ACS_PRESC_RST : presc_ff + 7'h01;
			start_d_ff <= ctrl.start;
			cmp_meta_ff <= cmp_above_pin;
			cmp_sync_ff <= cmp_meta_ff;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_ff <= 1'b0;
			irq_flag_ff <= 1'b0;
			irq_ff <= 1'b0;
			result_ff <= ACS_RESULT_RST;
		end else begin
			busy_ff <= (nxt_state == ACS_SAMPLE) || (nxt_state == ACS_CONVERT);
			if (done) irq_flag_ff <= 1'b1;
			else if (irq_flag_clear) irq_flag_ff <= 1'b0;
			irq_ff <= irq_now;
			if (done) result_ff <= final_code;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_ff <= '0;
			ref_ff <= 1'b0;
			power_ff <= 1'b0;
			sample_ff <= 1'b0;
			trial_ff <= '0;
		end else begin
			for (int i = 0; i < ACS_NUM_INPUTS; i++) begin
				sel_ff[i] <= ctrl.power_enable && (ctrl.input_channel_sel == ACS_CHAN_W'(i));
			end
			ref_ff <= ctrl.ref_source_sel == ACS_REF_SUPPLY;
			power_ff <= ctrl.power_enable;
			sample_ff <= nxt_state == ACS_SAMPLE;
			trial_ff <= sar_trial;
		end
	end

	// the dac's half-step offset sets where each output code turns over
	assign dac_trial = trial_ff;
	assign input_select = sel_ff;
	assign ref_from_supply = ref_ff;
	assign analog_power = power_ff;
	assign sample_switch = sample_ff;
	assign stat = '{busy: busy_ff, irq_flag: irq_flag_ff, irq: irq_ff, result: result_ff};

	// helper: busy cycles so far and the divider in force at launch, so the
	// conversion length is checked with a counter rather than a long repetition
	logic [10:0] busy_len_ff;
	logic [ACS_DIV_W-1:0] div_launch_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_len_ff <= 11'h000;
			div_launch_ff <= '0;
		end else begin
			busy_len_ff <= busy_ff ? busy_len_ff + 11'h001 : 11'h000;
			if (state_ff == ACS_HOLD && start_fall) div_launch_ff <= ctrl.clock_div_sel;
		end
	end

	property p_launch_busy;
		@(posedge clk) disable iff (!reset_n)
		(state_ff == ACS_HOLD && start_fall && ctrl.power_enable) |=> busy_ff;
	endproperty
	a_launch_busy: assert property (p_launch_busy) else $error("busy not set on launch");

	property p_hold_idle;
		@(posedge clk) disable iff (!reset_n)
		ctrl.start |=> !busy_ff;
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("busy while start held");

	property p_done_clears_busy;
		@(posedge clk) disable iff (!reset_n)
		done |=> !busy_ff && irq_flag_ff;
	endproperty
	a_done_clears_busy: assert property (p_done_clears_busy) else $error("end of conversion");

	property p_result_stable;
		@(posedge clk) disable iff (!reset_n)
		!done |=> $stable(result_ff);
	endproperty
	a_result_stable: assert property (p_result_stable) else $error("result moved");

	property p_abort;
		@(posedge clk) disable iff (!reset_n)
		(!ctrl.power_enable && !irq_flag_ff) |=> !busy_ff && !irq_flag_ff;
	endproperty
	a_abort: assert property (p_abort) else $error("abort failed");

	property p_conv_length;
		@(posedge clk) disable iff (!reset_n)
		(done && ctrl.clock_div_sel == div_launch_ff)
		|-> busy_len_ff == 11'((ACS_TOTAL_CLKS << div_launch_ff) - 1);
	endproperty
	a_conv_length: assert property (p_conv_length) else $error("conversion not twelve periods");

	property p_result_at_end;
		@(posedge clk) disable iff (!reset_n)
		$changed(result_ff) |-> $fell(busy_ff) && irq_flag_ff;
	endproperty
	a_result_at_end: assert property (p_result_at_end) else $error("result moved off completion");

	property p_sample_four;
		@(posedge clk) disable iff (!reset_n)
		(state_ff == ACS_SAMPLE && tick && cnt_ff == 4'h3 && !ctrl.start && ctrl.power_enable)
		|=> state_ff == ACS_CONVERT;
	endproperty
	a_sample_four: assert property (p_sample_four) else $error("sample phase length");

	property p_irq_gate;
		@(posedge clk) disable iff (!reset_n)
		irq_ff == $past(irq_now);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq gating");

	property p_flag_set_wins;
		@(posedge clk) disable iff (!reset_n)
		(done && irq_flag_clear) |=> irq_flag_ff;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("set lost to clear");
endmodule : acs_sequencer

//--- sim/acs_analog_model.sv
// behavioural analog front end: static inputs, reference choice and comparator
`timescale 1ns/1ps
module acs_analog_model
	import acs_pkg::*;
#(
	parameter logic [7:0] LEVEL [ACS_NUM_INPUTS] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40}
) (
	input wire logic clk,
	input wire logic [ACS_DATA_W-1:0] dac_trial,
	input wire logic [ACS_NUM_INPUTS-1:0] input_select,
	input wire logic ref_from_supply,
	input wire logic analog_power,
	output logic cmp_above_pin
);
	// inputs sit half a step above their code so no trial ever ties with them
	logic [9:0] vin2;
	logic wander = 1'b0;
	always @(posedge clk) wander <= ~wander;
	always_comb begin
		vin2 = 10'h000;
		for (int i = 0; i < ACS_NUM_INPUTS; i++) if (input_select[i]) vin2 = {1'b0, LEVEL[i], 1'b1};
	end
	// unpowered or floating: the comparator wanders rather than holding a stale level
	assign cmp_above_pin = (!analog_power || input_select == '0) ? wander :
		ref_from_supply ? ({1'b0, dac_trial, 1'b0} < vin2) :
		({dac_trial, 2'b00} < vin2); // pin reference is twice the supply
endmodule : acs_analog_model

//--- sim/acs_sequencer_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module acs_sequencer_test import acs_pkg::*; ();
	localparam logic [7:0] LVL [ACS_NUM_INPUTS] = '{8'h00, 8'h5a, 8'ha7, 8'h3c, 8'hff};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	acs_ctrl_s ctrl = '0;
	logic gie = 1'b0;
	logic cie = 1'b0;
	logic clr = 1'b0;
	logic cmp;
	logic [7:0] trial;
	logic [4:0] sel;
	logic ref_sup;
	logic pwr;
	logic smp;
	acs_stat_s stat;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;
	int smp_len;
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end
	acs_sequencer i_acs_sequencer (.clk(clk), .reset_n(reset_n), .ctrl(ctrl),
		.global_irq_enable(gie), .conv_irq_enable(cie), .irq_flag_clear(clr),
		.cmp_above_pin(cmp), .dac_trial(trial), .input_select(sel), .ref_from_supply(ref_sup),
		.analog_power(pwr), .sample_switch(smp), .stat(stat));
	acs_analog_model #(.LEVEL(LVL)) i_acs_analog_model (.clk(clk), .dac_trial(trial),
		.input_select(sel), .ref_from_supply(ref_sup), .analog_power(pwr), .cmp_above_pin(cmp));
	task automatic final_report();
		if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	task automatic pulse_start();
		@(negedge clk) ctrl.start = 1'b1;
		@(negedge clk) ctrl.start = 1'b0;
	endtask : pulse_start
	// waits for busy, then counts the cycles it and the sample switch stay high
	task automatic run(output int len);
		for (int w = 0; w < 4 && stat.busy !== 1'b1; w++) @(negedge clk);
		len = 0;
		smp_len = 0;
		while (stat.busy === 1'b1 && len < 2000) begin
			if (smp === 1'b1) smp_len++;
			@(negedge clk);
			len++;
		end
	endtask : run
	task automatic convert(input logic [2:0] div, output int len);
		ctrl.clock_div_sel = div;
		pulse_start();
		run(len);
	endtask : convert
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		`CHK("busy after reset", 1'b0, stat.busy)
		ctrl.power_enable = 1'b1;
		// channel switch and reference follow their codes, floating codes select nothing
		for (int c = 0; c < 16; c++) begin
			ctrl.input_channel_sel = 4'(c);
			ctrl.ref_source_sel = 2'(c);
			@(negedge clk);
			`CHK("input select", (c < 5) ? 5'(1 << c) : 5'h00, sel)
			`CHK("ref from supply", ((c % 4) == 1), ref_sup)
		end
		ctrl.ref_source_sel = ACS_REF_SUPPLY;
		for (int d = 0; d < 8; d++) begin
			ctrl.input_channel_sel = 4'(d % 5);
			convert(3'(d), n);
			`CHK("busy cycles", ACS_TOTAL_CLKS << d, n)
			`CHK("sample cycles", ACS_SAMPLE_CLKS << d, smp_len)
			// fast dividers outrun the comparator synchroniser, so the result is not checked there
			if (d >= 2) `CHK("result", LVL[d % 5], stat.result)
			`CHK("irq flag set", 1'b1, stat.irq_flag)
		end
		@(negedge clk) clr = 1'b1;
		@(negedge clk) clr = 1'b0;
		`CHK("irq flag cleared", 1'b0, stat.irq_flag)
		gie = 1'b1;
		cie = 1'b1;
		ctrl.ref_source_sel = 2'h2;
		ctrl.input_channel_sel = 4'h2;
		convert(3'h2, n);
		`CHK("pin ref result", LVL[2] >> 1, stat.result)
		@(negedge clk);
		`CHK("irq raised", 1'b1, stat.irq)
		cie = 1'b0;
		@(negedge clk) clr = 1'b1;
		@(negedge clk) clr = 1'b0;
		`CHK("irq masked", 1'b0, stat.irq)
		ctrl.ref_source_sel = ACS_REF_SUPPLY;
		ctrl.input_channel_sel = 4'h3;
		pulse_start();
		repeat (10) @(negedge clk);
		ctrl.power_enable = 1'b0;
		@(negedge clk);
		@(negedge clk);
		`CHK("abort busy", 1'b0, stat.busy)
		`CHK("abort no flag", 1'b0, stat.irq_flag)
		`CHK("abort result kept", LVL[2] >> 1, stat.result)
		`CHK("power off", 1'b0, pwr)
		`CHK("power off select", 5'h00, sel)
		ctrl.power_enable = 1'b1;
		pulse_start();
		repeat (10) @(negedge clk) ctrl.start = 1'b1;
		@(negedge clk);
		`CHK("start high resets", 1'b0, stat.busy)
		`CHK("result held", LVL[2] >> 1, stat.result)
		ctrl.start = 1'b0;
		run(n);
		`CHK("restart cycles", ACS_TOTAL_CLKS << 2, n)
		`CHK("restart sample cycles", ACS_SAMPLE_CLKS << 2, smp_len)
		`CHK("restart result", LVL[3], stat.result)
		final_report();
	end
endmodule : acs_sequencer_test
